// File: hdl/nsc_node_config.sv
// node configuration register bank of the packet switch
// assumes one config access per cycle, synchronous to mclk, power-on reset on arst_n
`timescale 1ns/1ps

// Function
// - identity register read-only: boot pins, revision, version bytes
// - topology register read-only: link count, switch and device processor counts
// - lock bit 31 set refuses writes to every switch control register
// - lock bit 8 set blocks writes to the pll register
// - bit 0 selects header length: 0 two bytes, 1 one byte
// - node number is writable 16 bits, resets to zero
// - any pll write resets the tile unless suppressed
// - pll write with bit 31 set applies settings without reset
// - pll write bit 30 skips waiting for relock
// - pll bit 29 bypasses the pll, input clock passes through
// - pll bit 28 forces boot from jtag port
// - output divider bits 25:23 ratio is field plus one
// - feedback multiplier bits 20:8 ratio is field plus one
// - input divider bits 6:0 ratio is field plus one
// - switch clock divider writable 16 bits, resets to zero
// - reference clock divider writable 16 bits, resets to three
// - user code read-only: otp user code high, metal id low 18 bits
// - most significant bit differing from node number picks the direction entry
// - low direction register holds dimensions 0 to 7, nibble each
// - high direction register holds dimensions 8 to 15, nibble each
module nsc_node_config #(
  parameter logic [7:0] SWITCH_VERSION = 8'h01, // arbitrary value
  parameter logic [7:0] SWITCH_REVISION = 8'h00, // arbitrary value
  parameter logic [7:0] SERIAL_LINK_COUNT = 8'h08,
  parameter logic [7:0] SWITCH_PROC_COUNT = 8'h02,
  parameter logic [7:0] DEVICE_PROC_COUNT = 8'h02,
  parameter logic [31:0] JTAG_ID_CODE = 32'h1234_5001, // arbitrary value
  parameter logic [17:0] METAL_ID_CODE = 18'h00001 // arbitrary value
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire logic [7:0] boot_control_pins,
  input wire logic [13:0] otp_user_code,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [nsc_pkg::ADDR_W-1:0] cfg_addr,
  input wire logic [nsc_pkg::DATA_W-1:0] cfg_wdata,
  output logic [nsc_pkg::DATA_W-1:0] cfg_rdata,
  output logic cfg_rvalid,
  output logic cfg_wr_refused,
  input wire logic pll_locked,
  output logic tile_reset,
  output logic pll_busy,
  output logic pll_bypass,
  output logic boot_from_jtag,
  output logic [7:0] pll_out_div_ratio,
  output logic [13:0] pll_fb_mul_ratio,
  output logic [7:0] pll_in_div_ratio,
  output logic one_byte_headers,
  output logic [15:0] switch_clock_div,
  output logic [15:0] reference_clock_div,
  input wire logic [15:0] route_dest,
  output logic route_local,
  output logic [3:0] route_dimension,
  output logic [3:0] route_direction
);
  import nsc_pkg::*;

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic boot_captured_q;
  logic [7:0] boot_pins_q;
  logic lock_all_q;
  logic lock_pll_q;
  logic one_byte_q;
  logic [15:0] node_number_q;
  logic [31:0] pll_settings_q;
  logic [15:0] switch_clk_div_q;
  logic [15:0] ref_clk_div_q;
  logic [31:0] dirs_low_q;
  logic [31:0] dirs_high_q;
  logic [31:0] rdata_q;
  logic rvalid_q;
  logic refused_q;
  nsc_pll_state_type pll_state_q;
  logic [3:0] reset_cnt_q;
  logic pll_no_wait_q;

  logic wr_ok;
  logic wr_pll;
  logic [31:0] rdata_d;

  // ------------------------------------------------------------
  // write qualification
  // ------------------------------------------------------------
  // lock register itself is also a switch control register, so the lock is sticky
  assign wr_ok = cfg_wr && !lock_all_q;
  assign wr_pll = wr_ok && (cfg_addr == REG_PLL_SETTINGS) && !lock_pll_q
    && (pll_state_q == PLL_IDLE);

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      refused_q <= 1'b0;
    end else if (clk_en) begin
      refused_q <= cfg_wr && (lock_all_q
        || ((cfg_addr == REG_PLL_SETTINGS) && (lock_pll_q || pll_state_q != PLL_IDLE)));
    end
  end

  // ------------------------------------------------------------
  // boot pin capture after power-on reset
  // ------------------------------------------------------------
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      boot_captured_q <= 1'b0;
      boot_pins_q <= 8'h00;
    end else if (clk_en && !boot_captured_q) begin
      boot_captured_q <= 1'b1;
      boot_pins_q <= boot_control_pins;
    end
  end

  // ------------------------------------------------------------
  // switch configuration and node number
  // ------------------------------------------------------------
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      lock_all_q <= 1'b0;
      lock_pll_q <= 1'b0;
      one_byte_q <= 1'b0;
    end else if (clk_en && wr_ok && cfg_addr == REG_SWITCH_LOCK_AND_HEADER) begin
      lock_all_q <= cfg_wdata[LOCK_ALL_BIT];
      lock_pll_q <= cfg_wdata[LOCK_PLL_BIT];
      one_byte_q <= cfg_wdata[HDR_ONE_BYTE_BIT];
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      node_number_q <= NODE_NUMBER_RESET;
    end else if (clk_en && wr_ok && cfg_addr == REG_NODE_NUMBER) begin
      node_number_q <= cfg_wdata[HALF_W-1:0];
    end
  end

  // ------------------------------------------------------------
  // clock dividers
  // ------------------------------------------------------------
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      switch_clk_div_q <= SWITCH_CLK_DIV_RESET;
    end else if (clk_en && wr_ok && cfg_addr == REG_SWITCH_CLOCK_DIVIDER) begin
      switch_clk_div_q <= cfg_wdata[HALF_W-1:0];
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ref_clk_div_q <= REF_CLK_DIV_RESET;
    end else if (clk_en && wr_ok && cfg_addr == REG_REFERENCE_CLOCK_DIVIDER) begin
      ref_clk_div_q <= cfg_wdata[HALF_W-1:0];
    end
  end

  // ------------------------------------------------------------
  // direction tables
  // ------------------------------------------------------------
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      dirs_low_q <= DIRECTIONS_RESET;
      dirs_high_q <= DIRECTIONS_RESET;
    end else if (clk_en && wr_ok) begin
      if (cfg_addr == REG_ROUTE_DIRECTIONS_LOW) begin
        dirs_low_q <= cfg_wdata;
      end
      if (cfg_addr == REG_ROUTE_DIRECTIONS_HIGH) begin
        dirs_high_q <= cfg_wdata;
      end
    end
  end

  // ------------------------------------------------------------
  // pll settings and tile reset sequencing
  // ------------------------------------------------------------
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pll_settings_q <= PLL_RESET_VAL;
    end else if (clk_en && wr_pll) begin
      pll_settings_q <= cfg_wdata & PLL_WRITE_MASK;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pll_state_q <= PLL_IDLE;
      reset_cnt_q <= 4'h0;
      pll_no_wait_q <= 1'b0;
    end else if (clk_en) begin
      unique case (pll_state_q)
        PLL_IDLE: begin
          if (wr_pll) begin
            pll_no_wait_q <= cfg_wdata[PLL_NO_RELOCK_WAIT_BIT];
            if (!cfg_wdata[PLL_NO_RESET_BIT]) begin
              pll_state_q <= PLL_RESET;
              reset_cnt_q <= TILE_RESET_CYCLES;
            end else if (!cfg_wdata[PLL_NO_RELOCK_WAIT_BIT]) begin
              pll_state_q <= PLL_WAIT_LOCK;
            end
          end
        end
        PLL_RESET: begin
          reset_cnt_q <= reset_cnt_q - 4'h1;
          if (reset_cnt_q == 4'h1) begin
            pll_state_q <= pll_no_wait_q ? PLL_IDLE : PLL_WAIT_LOCK;
          end
        end
        PLL_WAIT_LOCK: begin
          if (pll_locked) begin
            pll_state_q <= PLL_IDLE;
          end
        end
        default: begin
          pll_state_q <= PLL_IDLE;
        end
      endcase
    end
  end

  assign tile_reset = (pll_state_q == PLL_RESET);
  assign pll_busy = (pll_state_q != PLL_IDLE);
  assign pll_bypass = pll_settings_q[PLL_BYPASS_BIT];
  assign boot_from_jtag = pll_settings_q[PLL_BOOT_JTAG_BIT];
  assign pll_out_div_ratio = 8'(pll_settings_q[PLL_OUT_DIV_LSB +: PLL_OUT_DIV_W]) + 8'h01;
  assign pll_fb_mul_ratio = {1'b0, pll_settings_q[PLL_FB_MUL_LSB +: PLL_FB_MUL_W]} + 14'h0001;
  assign pll_in_div_ratio = {1'b0, pll_settings_q[PLL_IN_DIV_LSB +: PLL_IN_DIV_W]} + 8'h01;

  assign one_byte_headers = one_byte_q;
  assign switch_clock_div = switch_clk_div_q;
  assign reference_clock_div = ref_clk_div_q;

  // ------------------------------------------------------------
  // read path
  // ------------------------------------------------------------
  always_comb begin
    rdata_d = 32'h0000_0000;
    unique case (cfg_addr)
      REG_NODE_IDENTITY_INFO: rdata_d = {8'h00, boot_pins_q, SWITCH_REVISION, SWITCH_VERSION};
      REG_SWITCH_TOPOLOGY_INFO: begin
        rdata_d = {8'h00, SERIAL_LINK_COUNT, SWITCH_PROC_COUNT, DEVICE_PROC_COUNT};
      end
      REG_SWITCH_LOCK_AND_HEADER: begin
        rdata_d[LOCK_ALL_BIT] = lock_all_q;
        rdata_d[LOCK_PLL_BIT] = lock_pll_q;
        rdata_d[HDR_ONE_BYTE_BIT] = one_byte_q;
      end
      REG_NODE_NUMBER: rdata_d = {16'h0000, node_number_q};
      REG_PLL_SETTINGS: rdata_d = pll_settings_q;
      REG_SWITCH_CLOCK_DIVIDER: rdata_d = {16'h0000, switch_clk_div_q};
      REG_REFERENCE_CLOCK_DIVIDER: rdata_d = {16'h0000, ref_clk_div_q};
      REG_JTAG_IDENTITY: rdata_d = JTAG_ID_CODE;
      REG_USER_CODE: rdata_d = {otp_user_code, METAL_ID_CODE};
      REG_ROUTE_DIRECTIONS_LOW: rdata_d = dirs_low_q;
      REG_ROUTE_DIRECTIONS_HIGH: rdata_d = dirs_high_q;
      default: rdata_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_q <= 32'h0000_0000;
      rvalid_q <= 1'b0;
    end else if (clk_en) begin
      rvalid_q <= cfg_rd;
      if (cfg_rd) begin
        rdata_q <= rdata_d;
      end
    end
  end

  assign cfg_rdata = rdata_q;
  assign cfg_rvalid = rvalid_q;
  assign cfg_wr_refused = refused_q;

  // ------------------------------------------------------------
  // routing
  // ------------------------------------------------------------
  nsc_route_select u_route (
    .dest(route_dest),
    .node(node_number_q),
    .dirs_low(dirs_low_q),
    .dirs_high(dirs_high_q),
    .local_hit(route_local),
    .dimension(route_dimension),
    .direction(route_direction)
  );
endmodule

// File: pkg/nsc_pkg.sv
// node switch configuration register bank: shared constants and types
// assumes register numbers are word indices on a plain config access port
package nsc_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // register numbers
  localparam logic [7:0] REG_NODE_IDENTITY_INFO = 8'h00;
  localparam logic [7:0] REG_SWITCH_TOPOLOGY_INFO = 8'h01;
  localparam logic [7:0] REG_SWITCH_LOCK_AND_HEADER = 8'h04;
  localparam logic [7:0] REG_NODE_NUMBER = 8'h05;
  localparam logic [7:0] REG_PLL_SETTINGS = 8'h06;
  localparam logic [7:0] REG_SWITCH_CLOCK_DIVIDER = 8'h07;
  localparam logic [7:0] REG_REFERENCE_CLOCK_DIVIDER = 8'h08;
  localparam logic [7:0] REG_JTAG_IDENTITY = 8'h09;
  localparam logic [7:0] REG_USER_CODE = 8'h0A;
  localparam logic [7:0] REG_ROUTE_DIRECTIONS_LOW = 8'h0C;
  localparam logic [7:0] REG_ROUTE_DIRECTIONS_HIGH = 8'h0D;

  // switch_lock_and_header fields
  localparam int LOCK_ALL_BIT = 31;
  localparam int LOCK_PLL_BIT = 8;
  localparam int HDR_ONE_BYTE_BIT = 0;

  // pll_settings fields
  localparam int PLL_NO_RESET_BIT = 31;
  localparam int PLL_NO_RELOCK_WAIT_BIT = 30;
  localparam int PLL_BYPASS_BIT = 29;
  localparam int PLL_BOOT_JTAG_BIT = 28;
  localparam logic [31:0] PLL_WRITE_MASK = 32'hF39F_FF7F;
  localparam logic [31:0] PLL_RESET_VAL = 32'h0000_0000;
  localparam int PLL_OUT_DIV_LSB = 23;
  localparam int PLL_OUT_DIV_W = 3;
  localparam int PLL_FB_MUL_LSB = 8;
  localparam int PLL_FB_MUL_W = 13;
  localparam int PLL_IN_DIV_LSB = 0;
  localparam int PLL_IN_DIV_W = 7;

  // 16-bit registers, direction tables and their resets
  localparam int HALF_W = 16;
  localparam logic [15:0] NODE_NUMBER_RESET = 16'h0000;
  localparam logic [15:0] SWITCH_CLK_DIV_RESET = 16'h0000;
  localparam logic [15:0] REF_CLK_DIV_RESET = 16'h0003;
  localparam logic [31:0] DIRECTIONS_RESET = 32'h0000_0000;

  // identification byte fields
  localparam int BYTE_W = 8;
  localparam int USER_LOW_W = 18;
  localparam int USER_HIGH_W = 14;

  // routing
  localparam int DIR_W = 4;
  localparam int DIM_W = 4;
  localparam int DIMS_PER_REG = 8;

  // tile reset pulse length in cycles
  localparam logic [3:0] TILE_RESET_CYCLES = 4'h4;

  typedef enum logic [1:0] {
    PLL_IDLE = 2'b00,
    PLL_RESET = 2'b01,
    PLL_WAIT_LOCK = 2'b10
  } nsc_pll_state_type;
endpackage

// File: hdl/nsc_route_select.sv
// finds most significant differing bit between destination and node number
// assumes purely combinational use inside the register bank
`timescale 1ns/1ps
module nsc_route_select (
  input wire logic [15:0] dest,
  input wire logic [15:0] node,
  input wire logic [31:0] dirs_low,
  input wire logic [31:0] dirs_high,
  output logic local_hit,
  output logic [3:0] dimension,
  output logic [3:0] direction
);
  import nsc_pkg::*;

  logic [15:0] diff;
  logic [63:0] all_dirs;

  assign diff = dest ^ node;
  assign all_dirs = {dirs_high, dirs_low};
  assign local_hit = (diff == 16'h0000);

  always_comb begin
    dimension = 4'h0;
    for (int i = 0; i < 16; i++) begin
      if (diff[i]) begin
        dimension = 4'(i);
      end
    end
  end

  assign direction = all_dirs[dimension * DIR_W +: DIR_W];
endmodule

// File: tb/nsc_node_config_chk.sv
// ----------------------------------------
// port assertions for the node config bank
// ----------------------------------------
// assumes bind onto nsc_node_config, one mclk domain
`timescale 1ns/1ps
module nsc_node_config_chk (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire logic cfg_wr,
  input wire logic [7:0] cfg_addr,
  input wire logic [31:0] cfg_wdata,
  input wire logic cfg_wr_refused,
  input wire logic pll_locked,
  input wire logic tile_reset,
  input wire logic pll_busy,
  input wire logic pll_bypass,
  input wire logic boot_from_jtag,
  input wire logic [7:0] pll_out_div_ratio,
  input wire logic [7:0] pll_in_div_ratio,
  input wire logic one_byte_headers,
  input wire logic route_local
);
  import nsc_pkg::*;
  default clocking dcb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  logic pw;
  assign pw = cfg_wr && clk_en && cfg_addr == REG_PLL_SETTINGS;
  sequence pll_taken;
    pw ##1 !cfg_wr_refused;
  endsequence
  a_pll_ratio_load: assert property (pll_taken |-> pll_in_div_ratio == {1'b0, $past(cfg_wdata[6:0])} + 8'h01
    && pll_out_div_ratio == {5'h00, $past(cfg_wdata[25:23])} + 8'h01) else $error("pll ratio not loaded");
  a_pll_mode_load: assert property (pll_taken |-> pll_bypass == $past(cfg_wdata[29])
    && boot_from_jtag == $past(cfg_wdata[28])) else $error("pll mode bits not loaded");
  a_tile_reset_start: assert property (pw && !cfg_wdata[31] ##1 !cfg_wr_refused |-> tile_reset && pll_busy)
    else $error("pll write did not reset tile");
  a_tile_reset_len: assert property ($rose(tile_reset) |-> tile_reset [*4] ##1 !tile_reset)
    else $error("tile reset length wrong");
  a_no_reset_skip: assert property (pw && cfg_wdata[31] ##1 !cfg_wr_refused |-> !tile_reset [*4])
    else $error("tile reset despite suppress bit");
  a_relock_done: assert property (pll_busy && !tile_reset && pll_locked && clk_en |=> !pll_busy)
    else $error("busy after lock");
  a_skip_relock: assert property (pw && cfg_wdata[30] && !cfg_wdata[31] ##1 !cfg_wr_refused |-> ##[4:5] !pll_busy)
    else $error("relock wait not skipped");
  a_refuse_cause: assert property (cfg_wr_refused |-> $past(cfg_wr && clk_en))
    else $error("refusal without write");
  a_header_hold: assert property (!(cfg_wr && clk_en) |=> $stable(one_byte_headers))
    else $error("header mode changed without write");
  c_pll_write: cover property (pll_taken);
  c_refused: cover property (cfg_wr_refused);
  c_local: cover property (route_local);
endmodule

bind nsc_node_config nsc_node_config_chk i_nsc_node_config_chk (.mclk(mclk), .arst_n(arst_n), .clk_en(clk_en),
  .cfg_wr(cfg_wr), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_wr_refused(cfg_wr_refused),
  .pll_locked(pll_locked), .tile_reset(tile_reset), .pll_busy(pll_busy), .pll_bypass(pll_bypass),
  .boot_from_jtag(boot_from_jtag), .pll_out_div_ratio(pll_out_div_ratio), .pll_in_div_ratio(pll_in_div_ratio),
  .one_byte_headers(one_byte_headers), .route_local(route_local));

// File: tb/testbench.sv
// ----------------------------------------
// node config bank testbench
// ----------------------------------------
// assumes the checker is bound to the design
`timescale 1ns/1ps
module testbench;
  import nsc_pkg::*;
  localparam logic [7:0] VER = 8'h21; // arbitrary value
  localparam logic [7:0] REV = 8'h03; // arbitrary value
  localparam logic [31:0] JID = 32'h0BAD_0001; // arbitrary value
  localparam logic [17:0] MID = 18'h2A5A5; // arbitrary value
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic clk_en = 1'b1;
  logic [7:0] boot_control_pins = 8'hA5;
  logic [13:0] otp_user_code = 14'h2ABC;
  logic cfg_wr = 1'b0;
  logic cfg_rd = 1'b0;
  logic [7:0] cfg_addr = 8'h00;
  logic [31:0] cfg_wdata = 32'h0;
  logic pll_locked = 1'b0;
  logic [15:0] route_dest = 16'h0000;
  logic [31:0] cfg_rdata;
  logic cfg_rvalid, cfg_wr_refused, tile_reset, pll_busy, pll_bypass, boot_from_jtag, one_byte_headers;
  logic [7:0] pll_out_div_ratio, pll_in_div_ratio;
  logic [13:0] pll_fb_mul_ratio;
  logic [15:0] switch_clock_div, reference_clock_div;
  logic route_local;
  logic [3:0] route_dimension, route_direction;
  int error_cnt = 0;
  int checked = 0;
  always #50 mclk = ~mclk;
  nsc_node_config #(.SWITCH_VERSION(VER), .SWITCH_REVISION(REV), .SERIAL_LINK_COUNT(8'h04),
    .SWITCH_PROC_COUNT(8'h01), .DEVICE_PROC_COUNT(8'h02), .JTAG_ID_CODE(JID), .METAL_ID_CODE(MID))
  i_nsc_node_config (.mclk, .arst_n, .clk_en, .boot_control_pins, .otp_user_code, .cfg_wr, .cfg_rd,
    .cfg_addr, .cfg_wdata, .cfg_rdata, .cfg_rvalid, .cfg_wr_refused, .pll_locked, .tile_reset, .pll_busy,
    .pll_bypass, .boot_from_jtag, .pll_out_div_ratio, .pll_fb_mul_ratio, .pll_in_div_ratio, .one_byte_headers,
    .switch_clock_div, .reference_clock_div, .route_dest, .route_local, .route_dimension, .route_direction);
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic end_sim();
    $display("checked %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic c32(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic r);
    @(posedge mclk);
    cfg_wr <= 1'b1;
    cfg_addr <= a;
    cfg_wdata <= d;
    @(posedge mclk);
    cfg_wr <= 1'b0;
    #1;
    c32("refused", {31'h0, r}, {31'h0, cfg_wr_refused});
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    int i;
    @(posedge mclk);
    cfg_rd <= 1'b1;
    cfg_addr <= a;
    @(posedge mclk);
    cfg_rd <= 1'b0;
    #1;
    for (i = 0; i < 8 && cfg_rvalid !== 1'b1; i++) begin
      @(posedge mclk);
      #1;
    end
    if (i == 8) begin
      error_cnt++;
      end_sim();
    end else begin
      c32("rdata", e, cfg_rdata);
    end
  endtask
  task automatic idle();
    int i;
    for (i = 0; i < 40 && pll_busy !== 1'b0; i++) begin
      @(posedge mclk);
      #1;
    end
    if (i == 40) begin
      error_cnt++;
      end_sim();
    end
  endtask
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    int n;
    logic [15:0] dm;
    logic [63:0] dirs;
    repeat (4) @(posedge mclk);
    arst_n <= 1'b1;
    rd(8'h00, {8'h00, 8'hA5, REV, VER});
    boot_control_pins <= 8'h3C;
    rd(8'h01, 32'h0004_0102);
    rd(8'h04, 32'h0);
    rd(8'h05, 32'h0);
    rd(8'h07, 32'h0);
    rd(8'h08, 32'h3);
    rd(8'h0A, {otp_user_code, MID});
    rd(8'h0C, 32'h0);
    rd(8'h0D, 32'h0);
    rd(8'h02, 32'h0);
    c32("ratios", 32'h0101_0001, {pll_out_div_ratio, pll_in_div_ratio, 2'h0, pll_fb_mul_ratio});
    wr(8'h00, 32'hFFFF_FFFF, 1'b0);
    wr(8'h0A, 32'h0, 1'b0);
    rd(8'h00, {8'h00, 8'hA5, REV, VER});
    rd(8'h09, JID);
    $display("test reset and read-only done");
    wr(8'h05, 32'hFFFF_FFFF, 1'b0);
    rd(8'h05, 32'h0000_FFFF);
    wr(8'h07, 32'hFFFF_8001, 1'b0);
    wr(8'h08, 32'hABCD_1234, 1'b0);
    rd(8'h08, 32'h0000_1234);
    c32("clk div", 32'h8001_1234, {switch_clock_div, reference_clock_div});
    wr(8'h04, 32'h7FFF_FFFF, 1'b0);
    rd(8'h04, 32'h0000_0101);
    c32("one byte", 32'h1, {31'h0, one_byte_headers});
    wr(8'h04, 32'h0, 1'b0);
    c32("two byte", 32'h0, {31'h0, one_byte_headers});
    $display("test writable registers done");
    wr(8'h05, 32'h0000_8421, 1'b0);
    wr(8'h0C, 32'h0123_4567, 1'b0);
    wr(8'h0D, 32'h89AB_CDEF, 1'b0);
    rd(8'h0C, 32'h0123_4567);
    rd(8'h0D, 32'h89AB_CDEF);
    dirs = 64'h89AB_CDEF_0123_4567;
    for (int d = 0; d < 16; d++) begin
      @(posedge mclk);
      dm = 16'h0001 << d;
      route_dest <= 16'h8421 ^ (dm | (dm - 16'h0001));
      #1;
      c32("route", {23'h0, 1'b0, 4'(d), dirs[4*d +: 4]}, {23'h0, route_local, route_dimension, route_direction});
    end
    @(posedge mclk);
    route_dest <= 16'h8421;
    #1;
    c32("local", 32'h10, {27'h0, route_local, route_dimension});
    $display("test routing done");
    wr(8'h06, 32'h2C80_0A05, 1'b0);
    n = 0;
    while (tile_reset === 1'b1 && n < 20) begin
      @(posedge mclk);
      #1;
      n++;
    end
    c32("tile reset len", {28'h0, TILE_RESET_CYCLES}, n);
    c32("wait lock", 32'h1, {31'h0, pll_busy});
    wr(8'h06, 32'h0, 1'b1);
    @(posedge mclk);
    pll_locked <= 1'b1;
    idle();
    rd(8'h06, 32'h2080_0A05);
    c32("pll ratios", 32'h0206_000B, {pll_out_div_ratio, pll_in_div_ratio, 2'h0, pll_fb_mul_ratio});
    c32("pll mode", 32'h2, {30'h0, pll_bypass, boot_from_jtag});
    wr(8'h06, 32'hFFFF_FFFF, 1'b0);
    c32("no tile reset", 32'h0, {31'h0, tile_reset});
    idle();
    c32("pll max", 32'h0880_2000, {pll_out_div_ratio, pll_in_div_ratio, 2'h0, pll_fb_mul_ratio});
    c32("pll mode max", 32'h3, {30'h0, pll_bypass, boot_from_jtag});
    rd(8'h06, 32'hF39F_FF7F);
    @(posedge mclk);
    pll_locked <= 1'b0;
    wr(8'h06, 32'h4000_0000, 1'b0);
    idle();
    wr(8'h06, 32'h8000_0000, 1'b0);
    c32("wait no reset", 32'h1, {30'h0, tile_reset, pll_busy});
    @(posedge mclk);
    pll_locked <= 1'b1;
    idle();
    $display("test pll done");
    wr(8'h04, 32'h0000_0100, 1'b0);
    wr(8'h06, 32'h4000_0000, 1'b1);
    rd(8'h06, 32'h8000_0000);
    @(posedge mclk);
    clk_en <= 1'b0;
    wr(8'h05, 32'h1, 1'b0);
    @(posedge mclk);
    clk_en <= 1'b1;
    rd(8'h05, 32'h8421);
    wr(8'h04, 32'h8000_0000, 1'b0);
    wr(8'h05, 32'h1234, 1'b1);
    wr(8'h04, 32'h0, 1'b1);
    rd(8'h05, 32'h8421);
    rd(8'h04, 32'h8000_0000);
    @(posedge mclk);
    arst_n <= 1'b0;
    @(posedge mclk);
    arst_n <= 1'b1;
    rd(8'h04, 32'h0);
    rd(8'h05, 32'h0);
    rd(8'h00, {8'h00, 8'h3C, REV, VER});
    $display("test locks done");
    end_sim();
  end
endmodule
